// >>> lpidle_pkg.sv
// constants and types for the low-power idle clock divider
package lpidle_pkg;
    // divisor select codes carried by the idle instruction
    localparam logic [1:0] DIV_SEL_16  = 2'h0;
    localparam logic [1:0] DIV_SEL_32  = 2'h1;
    localparam logic [1:0] DIV_SEL_64  = 2'h2;
    localparam logic [1:0] DIV_SEL_128 = 2'h3;
    // divide counter width, enough for 128
    localparam int          CNT_W       = 7;
    // reset values
    localparam logic [6:0]  CNT_RST     = 7'h00;
    // wake-up latency in plain idle, in cycles
    localparam int          PLAIN_WAKE_CYCLES = 1;

    // controller states
    typedef enum logic [1:0] {
        LPIDLE_RUN_ST   = 2'b00,   // full-rate execution
        LPIDLE_IDLE_ST  = 2'b01,   // plain idle, core clock enable stopped
        LPIDLE_DIV_ST   = 2'b10,   // divided idle, slow enable
        LPIDLE_SVC_ST   = 2'b11    // waking: service then resume
    } lpidle_state_type;

    // last count (divisor minus one) for a divisor select
    function automatic logic [6:0] lpidle_div_last(input logic [1:0] sel);
        case (sel)
            DIV_SEL_16:  lpidle_div_last = 7'h0F;
            DIV_SEL_32:  lpidle_div_last = 7'h1F;
            DIV_SEL_64:  lpidle_div_last = 7'h3F;
            default:     lpidle_div_last = 7'h7F;
        endcase
    endfunction : lpidle_div_last
endpackage : lpidle_pkg

// >>> lpidle_divider.sv
// divide counter producing the slowed enable pulse
`timescale 1ns/1ps
`default_nettype none
module lpidle_divider
    import lpidle_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    // control
    input  wire logic       run_in,      // count while high
    input  wire logic [1:0] sel_in,      // divisor select
    // status
    output logic            tick_out,    // one-cycle pulse at divided boundary
    output logic [6:0]      count_out    // current count
);
    logic [6:0] cnt_ff;   // divide counter
    logic       tick_ff;  // boundary pulse

    ////////////////////////////////////////////////////////////////
    // counts master clock cycles, wraps at divisor
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_ff  <= CNT_RST;
            tick_ff <= 1'b0;
        end else if (!run_in) begin  // held at zero outside divided idle
            cnt_ff  <= CNT_RST;
            tick_ff <= 1'b0;
        end else if (cnt_ff >= lpidle_div_last(sel_in)) begin
            cnt_ff  <= CNT_RST;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 7'h01;
            tick_ff <= 1'b0;
        end
    end

    assign tick_out  = tick_ff;
    assign count_out = cnt_ff;
endmodule : lpidle_divider
`default_nettype wire

// >>> lpidle_ctrl.sv
// low-power idle controller with optional clock division
`timescale 1ns/1ps
`default_nettype none
module lpidle_ctrl
    import lpidle_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    // idle instruction decode from the sequencer
    input  wire logic       idle_exec_in,    // plain idle executed, pulse
    input  wire logic       idle_div_in,     // divided idle executed, pulse
    input  wire logic [1:0] idle_sel_in,     // divisor select 16/32/64/128
    // interrupt side
    input  wire logic       irq_in,          // enabled interrupt pending, level
    input  wire logic       irq_done_in,     // service routine returned, pulse
    // clock enables
    output logic            core_clk_en_out, // processor clock enable
    output logic            periph_clk_en_out, // serial and timer clock enable
    output logic            processor_clock_output, // divided output clock
    // sequencing
    output logic            halt_out,        // instruction fetch halted
    output logic            irq_take_out,    // vector to interrupt, pulse
    output logic            resume_next_out, // continue after idle, pulse
    output logic            idle_out         // controller is idle
);
    lpidle_state_type state_ff;       // controller state
    logic [1:0]       sel_ff;         // latched divisor select
    logic             core_en_ff;     // core enable
    logic             per_en_ff;      // peripheral enable
    logic             clk_out_ff;     // output clock level
    logic             halt_ff;        // halt flag
    logic             take_ff;        // vector pulse
    logic             resume_ff;      // resume pulse
    logic             idle_ff;        // idle flag, tracks the next state
    logic             tick;           // divided boundary pulse
    logic [6:0]       div_last;       // terminal count of the latched divisor
    logic [6:0]       count;          // divider count
    logic             div_run;        // divider running

    ////////////////////////////////////////////////////////////////
    // divider instance
    assign div_run = (state_ff == LPIDLE_DIV_ST);

    lpidle_divider u_div (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .run_in    (div_run),
        .sel_in    (sel_ff),
        .tick_out  (tick),
        .count_out (count)
    );

    ////////////////////////////////////////////////////////////////
    // state sequencing
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= LPIDLE_RUN_ST;
        end else begin
            case (state_ff)
                LPIDLE_RUN_ST: begin
                    if (idle_div_in) begin
                        state_ff <= LPIDLE_DIV_ST;
                    end else if (idle_exec_in) begin
                        state_ff <= LPIDLE_IDLE_ST;
                    end
                end
                LPIDLE_IDLE_ST: begin
                    if (irq_in) begin
                        state_ff <= LPIDLE_SVC_ST;
                    end
                end
                LPIDLE_DIV_ST: begin
                    if (irq_in && tick) begin
                        state_ff <= LPIDLE_SVC_ST;
                    end
                end
                LPIDLE_SVC_ST: begin
                    if (irq_done_in) begin
                        state_ff <= LPIDLE_RUN_ST;
                    end
                end
                default: begin
                    state_ff <= LPIDLE_RUN_ST;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // divisor latch, taken from the instruction
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_ff <= DIV_SEL_16;
        end else if (state_ff == LPIDLE_RUN_ST && idle_div_in) begin
            sel_ff <= idle_sel_in;
        end
    end

    ////////////////////////////////////////////////////////////////
    // idle flag, registered so the port comes from a flip-flop
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idle_ff <= 1'b0;
        end else begin
            case (state_ff)
                LPIDLE_RUN_ST: begin
                    idle_ff <= idle_exec_in | idle_div_in;
                end
                LPIDLE_IDLE_ST: begin
                    idle_ff <= ~irq_in;
                end
                LPIDLE_DIV_ST: begin
                    idle_ff <= ~(irq_in & tick);
                end
                default: begin
                    idle_ff <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // clock enables follow the next state, and in divided idle both pulse high on each tick while halt stays set
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_en_ff <= 1'b1;
            per_en_ff  <= 1'b1;
        end else begin
            case (state_ff)
                LPIDLE_RUN_ST: begin
                    if (idle_div_in) begin              // divided idle starts slow
                        core_en_ff <= 1'b0;
                        per_en_ff  <= 1'b0;
                    end else if (idle_exec_in) begin    // plain idle stops the core only
                        core_en_ff <= 1'b0;
                        per_en_ff  <= 1'b1;
                    end else begin
                        core_en_ff <= 1'b1;
                        per_en_ff  <= 1'b1;
                    end
                end
                LPIDLE_IDLE_ST: begin
                    core_en_ff <= irq_in;
                    per_en_ff  <= 1'b1;
                end
                LPIDLE_DIV_ST: begin
                    core_en_ff <= tick;
                    per_en_ff  <= tick;
                end
                default: begin
                    core_en_ff <= 1'b1;
                    per_en_ff  <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // output clock: toggles every cycle, in divided idle high while count is below half of div_last, so it slows with the divisor
    assign div_last = lpidle_div_last(sel_ff);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clk_out_ff <= 1'b0;
        end else if (div_run) begin
            clk_out_ff <= (count < {1'b0, div_last[6:1]}) ? 1'b1 : 1'b0;
        end else begin
            clk_out_ff <= ~clk_out_ff;
        end
    end

    ////////////////////////////////////////////////////////////////
    // halt, vector and resume sequencing
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            halt_ff   <= 1'b0;
            take_ff   <= 1'b0;
            resume_ff <= 1'b0;
        end else begin
            take_ff   <= 1'b0;
            resume_ff <= 1'b0;
            case (state_ff)
                LPIDLE_RUN_ST: begin
                    halt_ff <= idle_exec_in | idle_div_in;
                end
                LPIDLE_IDLE_ST: begin
                    if (irq_in) begin
                        halt_ff <= 1'b0;
                        take_ff <= 1'b1;
                    end
                end
                LPIDLE_DIV_ST: begin
                    if (irq_in && tick) begin
                        halt_ff <= 1'b0;
                        take_ff <= 1'b1;
                    end
                end
                LPIDLE_SVC_ST: begin
                    if (irq_done_in) begin
                        resume_ff <= 1'b1;
                    end
                end
                default: begin
                    halt_ff <= 1'b0;
                end
            endcase
        end
    end

    assign core_clk_en_out        = core_en_ff;
    assign periph_clk_en_out      = per_en_ff;
    assign processor_clock_output = clk_out_ff;
    assign halt_out               = halt_ff;
    assign irq_take_out           = take_ff;
    assign resume_next_out        = resume_ff;
    assign idle_out               = idle_ff;
endmodule : lpidle_ctrl
`default_nettype wire

// >>> lpidle_ctrl_sva.sv
// checker for the low-power idle clock controller
`timescale 1ns/1ps
`default_nettype none
module lpidle_ctrl_sva (
    input wire logic       mclk_in, rst_b_in, idle_exec_in, idle_div_in, irq_in, irq_done_in,
    input wire logic [1:0] idle_sel_in,
    input wire logic       core_clk_en_out, periph_clk_en_out, processor_clock_output,
    input wire logic       halt_out, irq_take_out, resume_next_out, idle_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // running at full rate, neither idle nor halted
    wire run = !idle_out && !halt_out;
    // remembers whether the current idle is the divided kind
    logic div_mode_ff;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) div_mode_ff <= 1'b0;
        else if (run && (idle_div_in || idle_exec_in)) div_mode_ff <= idle_div_in;
    end
    ////////////////////////////////////////////////////////////////
    a_idle_halts: assert property (run && (idle_exec_in || idle_div_in) |=> halt_out && idle_out)
        else $error("idle request did not halt");
    a_halt_stays: assert property (halt_out && !irq_in |=> halt_out)
        else $error("halt left without interrupt");
    a_take_once: assert property (irq_take_out |=> !irq_take_out && !halt_out)
        else $error("take not a single pulse");
    a_resume_done: assert property (run && irq_done_in |=> resume_next_out)
        else $error("no resume after service");
    a_div_gap: assert property (idle_out && core_clk_en_out && !irq_in |=> !core_clk_en_out [*8])
        else $error("divided enable too frequent");
    a_same_ratio: assert property (div_mode_ff && idle_out |-> periph_clk_en_out == core_clk_en_out)
        else $error("peripheral enable differs from core");
    a_plain_stop: assert property (!div_mode_ff && idle_out |-> !core_clk_en_out && periph_clk_en_out)
        else $error("core enable running in plain idle");
    a_full_rate: assert property (run |-> core_clk_en_out && periph_clk_en_out)
        else $error("enable low outside idle");
    a_wake_bound: assert property (halt_out && irq_in |-> ##[1:129] irq_take_out)
        else $error("wake-up too slow");
    a_out_toggle: assert property (run ##1 run |-> processor_clock_output != $past(processor_clock_output))
        else $error("output clock stalled");
endmodule : lpidle_ctrl_sva
bind lpidle_ctrl lpidle_ctrl_sva lpidle_ctrl_sva_inst (.mclk_in, .rst_b_in, .idle_exec_in, .idle_div_in,
    .irq_in, .irq_done_in, .idle_sel_in, .core_clk_en_out, .periph_clk_en_out, .processor_clock_output,
    .halt_out, .irq_take_out, .resume_next_out, .idle_out);
`default_nettype wire

// >>> lpidle_irq_model.sv
// interrupt source and service routine model
`timescale 1ns/1ps
`default_nettype none
module lpidle_irq_model (
    input  wire logic mclk_in, rst_b_in, fire_in, take_in,
    output logic      irq_out, done_out
);
    logic [2:0] svc_ff; // service countdown
    // one request outstanding, held until taken
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) irq_out <= 1'b0;
        else if (take_in) irq_out <= 1'b0;
        else if (fire_in && svc_ff == 3'h0) irq_out <= 1'b1;
    end
    // service routine returns three cycles after take
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) svc_ff <= 3'h0;
        else if (take_in) svc_ff <= 3'h3;
        else if (svc_ff != 3'h0) svc_ff <= svc_ff - 3'h1;
    end
    assign done_out = (svc_ff == 3'h1);
endmodule : lpidle_irq_model
`default_nettype wire

// >>> lpidle_tb.sv
// testbench for the low-power idle clock controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lpidle_pkg::*;
    logic       mclk_in = 1'b0, rst_b_in = 1'b0, idle_exec_in = 1'b0, idle_div_in = 1'b0, fire = 1'b0;
    logic [1:0] idle_sel_in = 2'h0;
    logic       irq_in, irq_done_in, core_clk_en_out, periph_clk_en_out, processor_clock_output;
    logic       halt_out, irq_take_out, resume_next_out, idle_out;
    int         errors = 0, comparisons = 0;
    initial forever #20 mclk_in = ~mclk_in;
    lpidle_ctrl lpidle_ctrl_inst (.mclk_in, .rst_b_in, .idle_exec_in, .idle_div_in, .idle_sel_in,
        .irq_in, .irq_done_in, .core_clk_en_out, .periph_clk_en_out, .processor_clock_output,
        .halt_out, .irq_take_out, .resume_next_out, .idle_out);
    lpidle_irq_model lpidle_irq_model_inst (.mclk_in, .rst_b_in, .fire_in(fire),
        .take_in(irq_take_out), .irq_out(irq_in), .done_out(irq_done_in));
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // advance one edge, then settle
    task automatic step;
        @(posedge mclk_in);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // cycles until a signal is high, bounded
    task automatic wait_hi(ref logic sig, input int lim, output int cyc);
        cyc = 0;
        while (sig !== 1'b1) begin
            step;
            cyc++;
            if (cyc > lim) begin
                errors++;
                stop_test;
            end
        end
    endtask : wait_hi
    // raise one interrupt, measure take, await resume
    task automatic wake(output int c);
        int r;
        fire = 1'b1;
        step;
        fire = 1'b0;
        wait_hi(irq_take_out, 200, c);
        wait_hi(resume_next_out, 8, r);
    endtask : wake
    ////////////////////////////////////////////////////////////////
    task automatic t_plain;
        int c;
        idle_exec_in = 1'b1;
        step;
        idle_exec_in = 1'b0;
        chk({halt_out, idle_out, core_clk_en_out}, 8'h06);
        repeat (9) step;
        chk(halt_out, 8'h01);
        wake(c);
        chk(8'(c), 8'(PLAIN_WAKE_CYCLES));
        chk({halt_out, resume_next_out}, 8'h01);
        $display("test plain idle done");
    endtask : t_plain
    task automatic t_div(input logic [1:0] sel);
        int c, n, r;
        logic p;
        n = 16 << sel;
        idle_sel_in = sel;
        idle_div_in = 1'b1;
        step;
        idle_div_in = 1'b0;
        idle_sel_in = ~sel;
        chk({halt_out, idle_out}, 8'h03);
        wait_hi(core_clk_en_out, 200, c);
        step;
        wait_hi(core_clk_en_out, 200, c);
        chk(8'(c + 1), 8'(n));
        chk(periph_clk_en_out, 8'h01);
        // output clock: exactly two rising edges in the next 2n cycles
        p = processor_clock_output;
        r = 0;
        repeat (2 * n) begin
            step;
            if (processor_clock_output && !p) r++;
            p = processor_clock_output;
        end
        chk(8'(r), 8'h02);
        wake(c);
        chk(8'(c <= n), 8'h01);
        chk({halt_out, idle_out, core_clk_en_out}, 8'h01);
        $display("test divided idle %0d done", n);
    endtask : t_div
    task automatic t_refuse;
        int c;
        fire = 1'b1;
        step;
        fire = 1'b0;
        repeat (20) step;
        chk({halt_out, irq_take_out}, 8'h00);
        idle_exec_in = 1'b1;
        step;
        idle_exec_in = 1'b0;
        wait_hi(irq_take_out, 4, c);
        chk(8'(c), 8'(PLAIN_WAKE_CYCLES));
        wait_hi(resume_next_out, 8, c);
        chk(resume_next_out, 8'h01);
        $display("test pending interrupt done");
    endtask : t_refuse
    initial begin
        repeat (12) @(posedge mclk_in);
        #1 rst_b_in = 1'b1;
        t_plain;
        for (int s = 0; s < 4; s++) t_div(2'(s));
        t_refuse;
        stop_test;
    end
endmodule : testbench
`default_nettype wire
